// *** rtl/flash_map_core.sv ***
// Storage core of a 4-Mbit serial NOR flash: main array, security regions,
// lock bits that only srst clears, and the read-only parameter space.
// Assumes a command decoder on clk_sys presents one operation at a time.
`include "flash_map_consts.svh"

module flash_map_core
  import flash_map_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        cmd_valid,
  input  wire flash_op_t   cmd_op,
  input  wire logic [23:0] cmd_addr,
  input  wire logic [7:0]  cmd_wdata,
  output logic      [7:0]  rd_data,
  output logic             rd_valid,
  output logic             op_done,
  output logic             op_error,
  output logic             busy,
  output logic      [2:0]  sec_lock
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [7:0] main_mem [0:`MAIN_BYTES-1]; // RULE_01
  logic [7:0] sec_mem  [0:`SEC_BYTES-1];  // RULE_05

  map_state_t             state_q,  state_d;
  logic [`MAIN_AW-1:0]    ptr_q,    ptr_d;
  logic [`MAIN_AW-1:0]    last_q,   last_d;
  logic                   er_sec_q, er_sec_d;
  logic [7:0]             rdata_q,  rdata_d;
  logic                   rvalid_q, rvalid_d;
  logic                   done_q,   done_d;
  logic                   err_q,    err_d;
  logic                   busy_q,   busy_d;
  logic [2:0]             lock_q,   lock_d;

  logic                   main_we;
  logic [`MAIN_AW-1:0]    main_wa;
  logic [7:0]             main_wd;
  logic                   sec_we;
  logic [`SEC_AW-1:0]     sec_wa;
  logic [7:0]             sec_wd;

  logic [7:0]             rom_data;
  logic                   main_ok;
  logic                   sec_ok;
  logic [1:0]             sec_rgn;
  logic [`SEC_AW-1:0]     sec_idx;
  logic                   sec_locked;
  logic [`MAIN_AW-1:0]    main_a;

  // ****************************************************************
  // Parameter space
  // ****************************************************************
  param_space_rom u_rom (
    .addr (cmd_addr[7:0]),
    .data (rom_data)
  );

  // ****************************************************************
  // Address decode
  // ****************************************************************
  always_comb begin
    main_a     = cmd_addr[`MAIN_AW-1:0];
    main_ok    = (cmd_addr[23:`MAIN_AW] == 5'h00);
    // Regions 1..3 sit at 0x001000, 0x002000, 0x003000; region 0 is the
    // parameter space and is never reachable by the security commands.
    sec_ok     = (cmd_addr[23:14] == 10'h000) && (cmd_addr[11:9] == 3'h0) &&
                 (cmd_addr[13:12] != 2'h0); // RULE_05 RULE_10
    sec_rgn    = cmd_addr[13:12] - 2'h1;
    sec_idx    = {sec_rgn, cmd_addr[`SEC_OFS_BITS-1:0]}; // RULE_07
    sec_locked = lock_q[sec_rgn];
  end

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    state_d  = state_q;
    ptr_d    = ptr_q;
    last_d   = last_q;
    er_sec_d = er_sec_q;
    rdata_d  = rdata_q;
    rvalid_d = 1'b0;
    done_d   = 1'b0;
    err_d    = 1'b0;
    busy_d   = busy_q;
    lock_d   = lock_q;
    main_we  = 1'b0;
    main_wa  = ptr_q;
    main_wd  = `ERASED_BYTE;
    sec_we   = 1'b0;
    sec_wa   = ptr_q[`SEC_AW-1:0];
    sec_wd   = `ERASED_BYTE;
    unique case (state_q)
      st_idle: begin
        if (cmd_valid) begin
          unique case (cmd_op)
            op_none: begin
            end
            op_read: begin
              rvalid_d = 1'b1;
              rdata_d  = main_ok ? main_mem[main_a] : `ERASED_BYTE;
              err_d    = !main_ok;
            end
            op_param_read: begin
              // Separate space; upper address bits beyond 256 bytes erased
              rvalid_d = 1'b1; // RULE_08 RULE_09
              rdata_d  = (cmd_addr[23:8] == 16'h0000) ? rom_data : `ERASED_BYTE; // RULE_17
            end
            op_page_prog: begin
              if (main_ok) begin
                main_we = 1'b1;
                main_wa = main_a;
                main_wd = main_mem[main_a] & cmd_wdata; // RULE_02
                done_d  = 1'b1;
              end else begin
                err_d = 1'b1;
              end
            end
            op_sector_erase: begin
              ptr_d    = {main_a[`MAIN_AW-1:`SECTOR_LSB], 12'h000}; // RULE_04
              last_d   = {main_a[`MAIN_AW-1:`SECTOR_LSB], 12'hfff}; // RULE_04
              er_sec_d = 1'b0;
              state_d  = st_erase; // RULE_03
              busy_d   = 1'b1;
            end
            op_block_erase: begin
              ptr_d    = {main_a[`MAIN_AW-1:`BLOCK_LSB], 16'h0000};
              last_d   = {main_a[`MAIN_AW-1:`BLOCK_LSB], 16'hffff};
              er_sec_d = 1'b0;
              state_d  = st_erase; // RULE_03
              busy_d   = 1'b1;
            end
            op_chip_erase: begin
              ptr_d    = '0;
              last_d   = `CHIP_LAST;
              er_sec_d = 1'b0;
              state_d  = st_erase; // RULE_03
              busy_d   = 1'b1;
            end
            op_sec_read: begin
              rvalid_d = 1'b1;
              rdata_d  = sec_ok ? sec_mem[sec_idx] : `ERASED_BYTE;
              err_d    = !sec_ok;
            end
            op_sec_prog: begin
              if (sec_ok && !sec_locked) begin // RULE_06 RULE_10
                sec_we = 1'b1;
                sec_wa = sec_idx;
                sec_wd = sec_mem[sec_idx] & cmd_wdata; // RULE_02
                done_d = 1'b1;
              end else begin
                err_d = 1'b1;
              end
            end
            op_sec_erase: begin
              if (sec_ok && !sec_locked) begin // RULE_06 RULE_07 RULE_10
                ptr_d    = {8'h00, sec_rgn, 9'h000};
                last_d   = {8'h00, sec_rgn, 9'h1ff};
                er_sec_d = 1'b1;
                state_d  = st_erase;
                busy_d   = 1'b1;
              end else begin
                err_d = 1'b1;
              end
            end
            op_sec_lock: begin
              if (sec_ok) begin
                // Only ever ORs in a one: only srst clears a lock, back to LOCK_RST
                lock_d[sec_rgn] = 1'b1; // RULE_06 RULE_07
                done_d          = 1'b1;
              end else begin
                err_d = 1'b1;
              end
            end
            default: begin
              err_d = 1'b1;
            end
          endcase
        end
      end
      st_erase: begin
        // One byte per cycle; slow for chip erase but needs no wide port
        if (er_sec_q) begin
          sec_we = 1'b1;
        end else begin
          main_we = 1'b1;
        end
        if (ptr_q == last_q) begin
          state_d = st_idle;
          busy_d  = 1'b0;
          done_d  = 1'b1;
        end else begin
          ptr_d = ptr_q + 19'h00001;
        end
      end
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q  <= st_idle;
      ptr_q    <= '0;
      last_q   <= '0;
      er_sec_q <= 1'b0;
      rdata_q  <= `ERASED_BYTE;
      rvalid_q <= 1'b0;
      done_q   <= 1'b0;
      err_q    <= 1'b0;
      busy_q   <= 1'b0;
      lock_q   <= `LOCK_RST;
    end else begin
      state_q  <= state_d;
      ptr_q    <= ptr_d;
      last_q   <= last_d;
      er_sec_q <= er_sec_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
      done_q   <= done_d;
      err_q    <= err_d;
      busy_q   <= busy_d;
      lock_q   <= lock_d;
    end
  end

  // Array contents are nonvolatile, so reset leaves them alone
  always_ff @(posedge clk_sys) begin
    if (main_we) begin
      main_mem[main_wa] <= main_wd;
    end
    if (sec_we) begin
      sec_mem[sec_wa] <= sec_wd;
    end
  end

  assign rd_data  = rdata_q;
  assign rd_valid = rvalid_q;
  assign op_done  = done_q;
  assign op_error = err_q;
  assign busy     = busy_q;
  assign sec_lock = lock_q;

endmodule

// *** rtl/flash_map_consts.svh ***
// Offsets, field positions, reset values and sizes of the flash address map.
// Assumes it is included by the design modules, not by the map package.
//
// Function
// RULE_01 - Main array: eight 64 KB blocks, 4 KB sectors, 256-byte pages.
// RULE_02 - Each page programs alone; programming only clears bits, never sets.
// RULE_03 - Erase by sector, block or whole chip; no page erase exists.
// RULE_04 - Sectors are aligned: low twelve address bits run 000 to fff.
// RULE_05 - Three 512-byte security regions stand apart from the main array.
// RULE_06 - A one-time lock bit protects its security region permanently. (Here srst clears lock_q to LOCK_RST.)
// RULE_07 - Security regions erase, program and lock independently.
// RULE_08 - Parameter read command reads a separate address space.
// RULE_09 - Region zero holds factory parameter data served by parameter read.
// RULE_10 - Parameter space is read-only; host program or erase cannot alter it.
// RULE_11 - Parameter header begins at byte zero and points to the tables.
// RULE_12 - Bytes from 0x20 are undefined space reserved for header growth.
// RULE_13 - Basic parameter table starts at offset 0x30.
// RULE_14 - Parameter data ends at 0x7b; 0x7c to 0xff are reserved.
// RULE_15 - Physical order is header first, then basic parameter table.
// RULE_16 - Parameter read enters at location zero, first signature byte.
// RULE_17 - Reserved or undefined parameter bytes read back as all ones.
`ifndef FLASH_MAP_CONSTS_SVH
`define FLASH_MAP_CONSTS_SVH

// ****************************************************************
// Array geometry
// ****************************************************************
`define MAIN_BYTES      524288
`define MAIN_AW         19
`define SECTOR_LSB      12
`define BLOCK_LSB       16
`define CHIP_LAST       19'h7ffff
`define ERASED_BYTE     8'hff

// ****************************************************************
// Security regions
// ****************************************************************
`define SEC_REGIONS     3
`define SEC_BYTES       1536
`define SEC_OFS_BITS    9
`define SEC_AW          11
`define LOCK_RST        3'h0

// ****************************************************************
// Parameter space map
// ****************************************************************
`define PS_HDR_START    8'h00
`define PS_HDR_LAST     8'h17
`define PS_HDR_RSVD     8'h20
`define PS_BASIC_START  8'h30
`define PS_END          8'h7b
`define PS_RSVD_START   8'h7c

`endif

// *** rtl/flash_map_pkg.sv ***
// Types shared by the flash address map design.
// Assumes flash_map_consts.svh sits beside it.
package flash_map_pkg;

  typedef enum logic [3:0] {
    op_none,
    op_read,
    op_param_read,
    op_page_prog,
    op_sector_erase,
    op_block_erase,
    op_chip_erase,
    op_sec_read,
    op_sec_prog,
    op_sec_erase,
    op_sec_lock
  } flash_op_t;

  typedef enum logic [1:0] {
    st_idle,
    st_erase
  } map_state_t;

endpackage

// *** rtl/param_space_rom.sv ***
// Read-only discoverable-parameter space, 256 bytes, combinational lookup.
// Assumes the caller registers the output; nothing can write it.
`include "flash_map_consts.svh"

module param_space_rom (
  input  wire logic [7:0] addr,
  output logic      [7:0] data
);

  // Arbitrary value: stands in for a maker code and names no real maker
  localparam logic [7:0] maker_code = 8'h3c;

  // ****************************************************************
  // Header first, all else erased; no basic table is held here
  // ****************************************************************
  always_comb begin
    data = `ERASED_BYTE; // RULE_17
    if (addr <= `PS_HDR_LAST) begin // RULE_11 RULE_15
      unique case (addr[4:0])
        5'h00: data = 8'h53; // RULE_16
        5'h01: data = 8'h46;
        5'h02: data = 8'h44;
        5'h03: data = 8'h50;
        5'h04: data = 8'h08;
        5'h05: data = 8'h01;
        5'h06: data = 8'h01;
        5'h07: data = 8'hff;
        5'h08: data = 8'h00;
        5'h09: data = 8'h07;
        5'h0a: data = 8'h01;
        5'h0b: data = 8'h10;
        5'h0c: data = `PS_BASIC_START; // RULE_13
        5'h0d: data = 8'h00;
        5'h0e: data = 8'h00;
        5'h0f: data = 8'hff;
        5'h10: data = maker_code;
        5'h11: data = 8'h00;
        5'h12: data = 8'h01;
        5'h13: data = 8'h03;
        5'h14: data = 8'h70;
        5'h15: data = 8'h00;
        5'h16: data = 8'h00;
        5'h17: data = 8'hff;
        default: data = `ERASED_BYTE;
      endcase
    end
    // Bytes from the reserved header area up to the basic table start
    // stay erased here; this module holds no table contents.
    if (addr >= `PS_HDR_RSVD && addr < `PS_BASIC_START) begin
      data = `ERASED_BYTE; // RULE_12
    end
    if (addr >= `PS_RSVD_START) begin
      data = `ERASED_BYTE; // RULE_14
    end
  end

endmodule

// *** tb/flash_map_core_assertions.sv ***
// Port checker for the flash map core.
// Assumes a bind from the bench top; sees only the core's ports.
module flash_map_checker
  import flash_map_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        cmd_valid,
  input wire flash_op_t   cmd_op,
  input wire logic [23:0] cmd_addr,
  input wire logic [7:0]  cmd_wdata,
  input wire logic [7:0]  rd_data,
  input wire logic        rd_valid,
  input wire logic        op_done,
  input wire logic        op_error,
  input wire logic        busy,
  input wire logic [2:0]  sec_lock
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic        take;
  logic [19:0] busy_cnt_d;
  logic [19:0] busy_cnt_q;
  assign take = cmd_valid && !busy;
  // Counts busy cycles so each erase length can be judged at its end
  always_comb begin
    busy_cnt_d = busy ? busy_cnt_q + 20'h1 : 20'h0;
  end
  always_ff @(posedge clk_sys) begin
    busy_cnt_q <= busy_cnt_d;
  end
  chk_read_answer: assert property (
    take && cmd_op == op_read
    |=> rd_valid && (op_error == ($past(cmd_addr[23:19]) != 5'h00)))
    else $error("read answer wrong");
  chk_prog_answer: assert property (
    take && cmd_op == op_page_prog |=> op_done != op_error) else $error("prog answer wrong");
  chk_erase_start: assert property (
    take && cmd_op inside {op_sector_erase, op_block_erase} |=> busy) else $error("no busy");
  chk_erase_span: assert property (
    $fell(busy) |-> op_done && busy_cnt_q inside {20'd512, 20'd4096, 20'd65536, 20'd524288})
    else $error("erase length wrong");
  chk_lock_sticky: assert property (
    (sec_lock & $past(sec_lock)) == $past(sec_lock)) else $error("lock bit cleared");
  chk_locked_refuse: assert property (
    take && cmd_op inside {op_sec_prog, op_sec_erase} && cmd_addr[23:9] == 15'h0008
    && sec_lock[0] |=> op_error && !busy) else $error("locked region altered");
  chk_param_entry: assert property (
    take && cmd_op == op_param_read && cmd_addr == 24'h0 |=> rd_valid && rd_data == 8'h53)
    else $error("entry byte wrong");
  chk_param_rsvd: assert property (
    take && cmd_op == op_param_read && cmd_addr[23:8] == 16'h0 && cmd_addr[7:0] >= 8'h20
    |=> rd_data == 8'hff) else $error("reserved byte not ff");
  chk_param_ro: assert property (
    take && cmd_op inside {op_sec_prog, op_sec_erase} && cmd_addr[23:9] == 15'h0
    |=> op_error) else $error("param space writable");
  cov_erase_end: cover property ($fell(busy) && op_done);
  cov_lock: cover property ($rose(sec_lock[0]));
  cov_param: cover property (take && cmd_op == op_param_read);
endmodule

// *** tb/flash_host_model.sv ***
// Host controller model issuing one-byte flash commands.
// Assumes the core takes a command on the edge after cmd_valid rises.
module flash_host_model
  import flash_map_pkg::*;
(
  input  wire logic        clk_sys,
  output flash_op_t        cmd_op,
  output logic             cmd_valid,
  output logic      [23:0] cmd_addr,
  output logic      [7:0]  cmd_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_valid = 1'b0;
    cmd_op    = op_none;
    cmd_addr  = 24'h0;
    cmd_wdata = 8'h0;
  end
  // Released address and data lines show the inverse so stale values never look valid
  task automatic issue(input flash_op_t op, input logic [23:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_op    <= op;
    cmd_addr  <= a;
    cmd_wdata <= d;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    cmd_op    <= op_none;
    cmd_addr  <= ~a;
    cmd_wdata <= ~d;
  endtask
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the flash map core.
// Assumes the host model drives all command inputs.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_map_pkg::*;
  logic        clk_sys, srst, cmd_valid, rd_valid, op_done, op_error, busy;
  flash_op_t   cmd_op;
  logic [23:0] cmd_addr;
  logic [7:0]  cmd_wdata, rd_data;
  logic [2:0]  sec_lock;
  int          failures, cmp_count;
  flash_host_model host_u (.clk_sys(clk_sys), .cmd_op(cmd_op), .cmd_valid(cmd_valid),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata));
  flash_map_core dut_u (.clk_sys(clk_sys), .srst(srst), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rd_data(rd_data),
    .rd_valid(rd_valid), .op_done(op_done), .op_error(op_error), .busy(busy),
    .sec_lock(sec_lock));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  task automatic cmd(input flash_op_t op, input logic [23:0] a, input logic [7:0] d);
    host_u.issue(op, a, d);
    #1;
  endtask
  task automatic rd(input flash_op_t op, input logic [23:0] a, input logic [7:0] e);
    cmd(op, a, 8'h00);
    chk(20'(rd_valid), 20'h1, "rd_valid");
    chk(20'(rd_data), 20'(e), "rd_data");
  endtask
  task automatic wr(input flash_op_t op, input logic [23:0] a, input logic [7:0] d,
                    input logic e);
    cmd(op, a, d);
    chk(20'(op_done), 20'(!e), "op_done");
    chk(20'(op_error), 20'(e), "op_error");
  endtask
  task automatic erase(input flash_op_t op, input logic [23:0] a, input logic [19:0] len);
    logic [19:0] n;
    n = 20'h0;
    cmd(op, a, 8'h00);
    while (busy === 1'b1 && n < 20'd70000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(n, len, "erase length");
    chk(20'(op_done), 20'h1, "erase done");
  endtask
  // Chip erase runs far too long to finish here; a mid-run reset cuts it short
  task automatic t_chip();
    cmd(op_chip_erase, 24'h000000, 8'h00);
    chk(20'(busy), 20'h1, "chip busy");
    repeat (300) @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    #1;
    chk(20'(busy), 20'h0, "mid reset busy");
    chk(20'(rd_data), 20'hff, "mid reset data");
    rd(op_read, 24'h000100, 8'hff);
  endtask
  task automatic t_param();
    logic [7:0] pa[9] = '{8'h00, 8'h01, 8'h0c, 8'h17, 8'h20, 8'h30, 8'h7b, 8'h7c, 8'hff};
    logic [7:0] pe[9] = '{8'h53, 8'h46, 8'h30, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
    for (int i = 0; i < 9; i++) begin
      rd(op_param_read, {16'h0, pa[i]}, pe[i]);
    end
    wr(op_sec_prog, 24'h000000, 8'h00, 1'b1);
    wr(op_sec_erase, 24'h000000, 8'h00, 1'b1);
    rd(op_param_read, 24'h000000, 8'h53);
  endtask
  task automatic t_main();
    erase(op_sector_erase, 24'h001abc, 20'd4096);
    rd(op_read, 24'h001000, 8'hff);
    rd(op_read, 24'h001fff, 8'hff);
    wr(op_page_prog, 24'h001010, 8'h5a, 1'b0);
    wr(op_page_prog, 24'h001010, 8'hf0, 1'b0);
    rd(op_read, 24'h001010, 8'h50);
    rd(op_read, 24'h001110, 8'hff);
    wr(op_read, 24'h080000, 8'h00, 1'b1);
    erase(op_block_erase, 24'h071234, 20'd65536);
    rd(op_read, 24'h070000, 8'hff);
    rd(op_read, 24'h07ffff, 8'hff);
  endtask
  task automatic t_sec();
    erase(op_sec_erase, 24'h001000, 20'd512);
    erase(op_sec_erase, 24'h002000, 20'd512);
    wr(op_sec_prog, 24'h001005, 8'ha5, 1'b0);
    rd(op_sec_read, 24'h001005, 8'ha5);
    rd(op_read, 24'h001005, 8'hff);
    wr(op_sec_prog, 24'h001200, 8'h00, 1'b1);
    wr(op_sec_lock, 24'h001000, 8'h00, 1'b0);
    chk(20'(sec_lock), 20'h1, "lock bits");
    wr(op_sec_prog, 24'h001006, 8'h00, 1'b1);
    wr(op_sec_erase, 24'h001000, 8'h00, 1'b1);
    rd(op_sec_read, 24'h001006, 8'hff);
    wr(op_sec_prog, 24'h002007, 8'h3c, 1'b0);
    rd(op_sec_read, 24'h002007, 8'h3c);
    chk(20'(sec_lock), 20'h1, "lock bits");
  endtask
  task automatic results();
    $display("failures %0d cmp_count %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    srst = 1'b1;
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    #1;
    chk(20'(rd_data), 20'hff, "reset data");
    chk(20'(busy), 20'h0, "reset busy");
    t_param();
    t_main();
    t_sec();
    t_chip();
    results();
  end
  // Whole run needs about 71k cycles
  initial begin
    repeat (80000) @(posedge clk_sys);
    failures++;
    results();
  end
endmodule
bind flash_map_core flash_map_checker chk_u (.clk_sys(clk_sys), .srst(srst),
  .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
  .rd_data(rd_data), .rd_valid(rd_valid), .op_done(op_done), .op_error(op_error),
  .busy(busy), .sec_lock(sec_lock));
